// [common/dsfr_pkg.sv]
// constants and types shared by the ds1 off-line receive framer
package dsfr_pkg;

   // -----------------------------------------------------------------
   // line format
   // -----------------------------------------------------------------
   localparam int BITS_PER_FRAME = 193;
   localparam logic [7:0] FRAME_LAST_BIT = 8'(BITS_PER_FRAME - 1);
   localparam logic [4:0] ESF_LAST_FRAME = 5'h17;
   localparam logic [4:0] D4_LAST_FRAME = 5'h0B;
   localparam int MEM_DEPTH = 4 * BITS_PER_FRAME;
   localparam logic [9:0] ESF_SPAN = 10'(4 * BITS_PER_FRAME);
   localparam logic [9:0] D4_SPAN = 10'(2 * BITS_PER_FRAME);
   // oldest bit in bit 5
   localparam logic [5:0] FPS_PAT = 6'h0B;
   localparam logic [5:0] FS_PAT = 6'h0E;

   // -----------------------------------------------------------------
   // hunt and loss thresholds
   // -----------------------------------------------------------------
   localparam logic [3:0] HUNT_D4 = 4'hA;
   localparam logic [3:0] HUNT_ESF = 4'h4;
   localparam logic [3:0] CNT_MAX = 4'hF;
   localparam logic [2:0] FS_FILL = 3'h6;
   localparam int NARROW_WIN = 4;
   localparam logic [3:0] NARROW_ERR = 4'h2;
   localparam int WIDE_WIN = 12;
   localparam logic [3:0] WIDE_ERR = 4'h4;

   // -----------------------------------------------------------------
   // frame reference: high part in line bits, 47 us at 1.544 MHz
   // -----------------------------------------------------------------
   localparam logic [7:0] REF_HIGH_BITS = 8'h49;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam logic [7:0] CTRL1_ADDR = 8'h00;
   localparam logic [7:0] CTRL2_ADDR = 8'h04;
   localparam logic [7:0] STAT1_ADDR = 8'h08;
   localparam logic [7:0] POS_ADDR = 8'h0C;
   localparam int CTRL1_ESF_BIT = 0;
   localparam int CTRL1_CRCMIM_BIT = 1;
   localparam int CTRL2_OOS_BIT = 0;
   localparam int CTRL2_REFRAME_BIT = 1;
   localparam int STAT_TERM_BIT = 0;
   localparam int STAT_FREEZE_BIT = 1;
   localparam int STAT_HUNT_BIT = 2;
   localparam int STAT_MF_BIT = 3;
   localparam int STAT_SPLIT_LSB = 4;
   localparam int POS_FRAME_LSB = 8;
   localparam logic CTRL_RST = 1'h0;
   localparam logic SYNC_LOST_RST = 1'h1;

   typedef enum {FR_HUNT, FR_CONFIRM, FR_SYNC} dsfr_state_t;

endpackage

// [rtl/dsfr_sync.sv]
// two-flop synchroniser for line pins
`timescale 1ns/1ps
module dsfr_sync #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // pins and synchronised copy
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] pinSync
);
   logic [W-1:0] stage1_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage1_q <= '0;
         pinSync <= '0;
      end else begin
         stage1_q <= pinIn;
         pinSync <= stage1_q;
      end
   end
endmodule // dsfr_sync

// [rtl/dsfr_oos_mon.sv]
// framing-bit error window, m errors out of n checks
`timescale 1ns/1ps
module dsfr_oos_mon import dsfr_pkg::*; #(
   parameter int WIN = WIDE_WIN
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // framing bit checks
   input wire logic chk,
   input wire logic err,
   input wire logic wide,
   input wire logic clr,
   // loss of sync pulse
   output logic lost
);
   logic [WIN-1:0] hist_q;
   logic [WIN-1:0] hist_d;
   logic [3:0] narrowCnt;
   logic [3:0] wideCnt;
   logic tooMany;

   assign hist_d = {hist_q[WIN-2:0], err};

   always_comb begin
      narrowCnt = '0;
      wideCnt = '0;
      for (int i = 0; i < WIN; i++) begin
         if (i < NARROW_WIN) begin
            narrowCnt = narrowCnt + 4'(hist_d[i]);
         end
         wideCnt = wideCnt + 4'(hist_d[i]);
      end
   end

   assign tooMany = wide ? (wideCnt >= WIDE_ERR) : (narrowCnt >= NARROW_ERR);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hist_q <= '0;
         lost <= 1'b0;
      end else begin
         if (clr) begin
            hist_q <= '0;
         end else if (chk) begin
            hist_q <= hist_d;
         end
         lost <= chk & tooMany & ~clr;
      end
   end
endmodule // dsfr_oos_mon

// [rtl/dsfr_framer.sv]
// ds1 off-line receive framer with apb registers
//
// What this block does
// - esf mode hunts for the fps pattern
// - d3/d4 hunts alternating ft bit position
// - ft lock clears status bit 0
// - after ft lock, search fs pattern
// - fs found clears status bit 3
// - terminal sync kept without fs pattern
// - mimic bit clear: need exactly one candidate
// - mimic bit set: lock first candidate
// - receive timing moves only on new position
// - counters hold position until new lock, or for the frame count an fs find
// - ctrl2 bit 0 picks 2/4 or 4/12
// - esf without crc screens for mimics
// - line clock divided by 193 gives 8k
// - 8k reference aligned to frame boundary
// - line data sampled on falling line clock
// - signalling frozen while terminal sync lost
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dsfr_framer import dsfr_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // line receiver
   input wire logic extractedLineClockIn,
   input wire logic splitPhasePositiveInN,
   input wire logic splitPhaseNegativeInN,
   input wire logic compositeDataIn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // framer outputs
   output logic recoveredFrameRefOut,
   output logic signallingFreeze
);

   // -----------------------------------------------------------------
   // window match against a rotated six-bit pattern
   // -----------------------------------------------------------------
   function automatic logic [3:0] rot_match(input logic [5:0] w, input logic [5:0] pat);
      logic [3:0] res;
      logic ok;
      res = '0;
      for (int i = 0; i < 6; i++) begin
         ok = 1'b1;
         for (int k = 0; k < 6; k++) begin
            if (w[5-k] != pat[5-((i+1+k)%6)]) begin
               ok = 1'b0;
            end
         end
         if (ok && !res[3]) begin
            res = {1'b1, 3'(i)};
         end
      end
      return res;
   endfunction

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic [3:0] pinSync;
   logic lineClkS;
   logic posS;
   logic negS;
   logic dataS;
   logic clkPrev_q;
   logic bitStb;
   logic rxBitVal;
   logic [1:0] split_q;

   logic esf_q;
   logic crcMimic_q;
   logic oosWide_q;
   logic termLost_q;
   logic mfLost_q;
   logic refOut_q;
   logic [31:0] prdata_q;

   dsfr_state_t state_q;
   dsfr_state_t state_d;
   logic [9:0] srch_q;
   logic [9:0] span;
   logic srchLast;
   logic primed_q;
   logic [9:0] histMem [MEM_DEPTH];
   logic [9:0] entry;
   logic [5:0] newWin;
   logic [3:0] oldCnt;
   logic [3:0] newCnt;
   logic [3:0] esfHit;
   logic match;
   logic qualify;
   logic uniqueChk;
   logic [1:0] candN_q;
   logic [1:0] candNNext;
   logic [9:0] candPos_q;
   logic atCand;
   logic lockNow;
   logic dropSync;
   logic [4:0] lockFrame;

   logic [7:0] rxBit_q;
   logic [7:0] rxBit_d;
   logic [4:0] rxFrame_q;
   logic [4:0] rxFrame_d;
   logic [4:0] frameLast;
   logic fbit;
   logic ftSlot;
   logic fsSlot;
   logic fpsSlot;
   logic lastFt_q;
   logic fpsExp;
   logic chk;
   logic err;
   logic oosLost;
   logic [5:0] fsWin_q;
   logic [2:0] fsCnt_q;
   logic [3:0] fsHit;
   logic fsFound;
   logic [4:0] fsFrame;

   logic setup;
   logic access;
   logic wrEn;
   logic selCtrl1;
   logic selCtrl2;
   logic selStat1;
   logic selPos;
   logic mapped;
   logic modeChg;
   logic forceReframe;
   logic [31:0] rdMux;

   // -----------------------------------------------------------------
   // line sampling
   // -----------------------------------------------------------------
   dsfr_sync #(.W(4)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .pinIn({extractedLineClockIn, splitPhasePositiveInN, splitPhaseNegativeInN,
              compositeDataIn}),
      .pinSync(pinSync)
   );

   assign lineClkS = pinSync[3];
   assign posS = pinSync[2];
   assign negS = pinSync[1];
   assign dataS = pinSync[0];
   assign bitStb = clkPrev_q & ~lineClkS;
   assign rxBitVal = dataS;

   // -----------------------------------------------------------------
   // candidate hunt over one frame pair or one fps span
   // -----------------------------------------------------------------
   assign span = esf_q ? ESF_SPAN : D4_SPAN;
   assign srchLast = (srch_q == span - 10'h001);
   assign entry = primed_q ? histMem[srch_q] : 10'h000;
   assign oldCnt = entry[9:6];
   assign newWin = {entry[4:0], rxBitVal};
   assign esfHit = rot_match(newWin, FPS_PAT);
   assign match = esf_q ? esfHit[3] : (rxBitVal != entry[0]);
   assign newCnt = !match ? 4'h0 : (oldCnt == CNT_MAX) ? CNT_MAX : oldCnt + 4'h1;
   assign qualify = bitStb & (newCnt >= (esf_q ? HUNT_ESF : HUNT_D4));
   assign uniqueChk = ~crcMimic_q;
   assign candNNext = (qualify && candN_q != 2'h2) ? candN_q + 2'h1 : candN_q;
   assign atCand = bitStb & (srch_q == candPos_q);
   assign lockNow = ~dropSync & qualify &
                    (((state_q == FR_HUNT) & ~uniqueChk) |
                     ((state_q == FR_CONFIRM) & atCand));
   assign dropSync = oosLost | forceReframe | modeChg;
   assign lockFrame = esf_q ? {esfHit[2:0], 2'b11} : 5'h00;

   always_ff @(posedge ref_clk) begin
      if (bitStb) begin
         histMem[srch_q] <= {newCnt, newWin};
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         FR_HUNT: begin
            if (lockNow) begin
               state_d = FR_SYNC;
            end else if (bitStb && srchLast && uniqueChk && candNNext == 2'h1) begin
               state_d = FR_CONFIRM;
            end
         end
         FR_CONFIRM: begin
            if (lockNow) begin
               state_d = FR_SYNC;
            end else if (atCand) begin
               state_d = FR_HUNT;
            end
         end
         FR_SYNC: begin
            state_d = FR_SYNC;
         end
         default: begin
            state_d = FR_HUNT;
         end
      endcase
      if (dropSync) begin
         state_d = FR_HUNT;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= FR_HUNT;
         srch_q <= '0;
         primed_q <= 1'b0;
         candN_q <= '0;
         candPos_q <= '0;
         clkPrev_q <= 1'b0;
         split_q <= '0;
      end else begin
         state_q <= state_d;
         clkPrev_q <= lineClkS;
         if (bitStb) begin
            split_q <= {posS, negS};
            srch_q <= (srchLast || srch_q >= span) ? 10'h000 : srch_q + 10'h001;
         end
         if (modeChg) begin
            primed_q <= 1'b0;
         end else if (bitStb && srchLast) begin
            primed_q <= 1'b1;
         end
         if (state_q != FR_HUNT || (bitStb && srchLast)) begin
            candN_q <= '0;
         end else begin
            candN_q <= candNNext;
         end
         if (state_q == FR_HUNT && qualify && candN_q == 2'h0) begin
            candPos_q <= srch_q;
         end
      end
   end

   // -----------------------------------------------------------------
   // receive counters, moved only by a lock or, for the frame count, by an fs find
   // -----------------------------------------------------------------
   assign frameLast = esf_q ? ESF_LAST_FRAME : D4_LAST_FRAME;

   always_comb begin
      rxBit_d = rxBit_q;
      rxFrame_d = rxFrame_q;
      if (bitStb) begin
         if (rxBit_q >= FRAME_LAST_BIT) begin
            rxBit_d = 8'h00;
            rxFrame_d = (rxFrame_q >= frameLast) ? 5'h00 : rxFrame_q + 5'h01;
         end else begin
            rxBit_d = rxBit_q + 8'h01;
         end
      end
      if (lockNow) begin
         rxBit_d = 8'h01;
         rxFrame_d = lockFrame;
      end else if (fsFound) begin
         rxFrame_d = fsFrame;
      end
   end

   // -----------------------------------------------------------------
   // maintenance checks on framing bits
   // -----------------------------------------------------------------
   assign fbit = bitStb & (state_q == FR_SYNC) & (rxBit_q == 8'h00);
   assign ftSlot = ~esf_q & ~rxFrame_q[0];
   assign fsSlot = ~esf_q & rxFrame_q[0];
   assign fpsSlot = esf_q & (rxFrame_q[1:0] == 2'b11);
   assign fpsExp = FPS_PAT[3'h5 - rxFrame_q[4:2]];
   assign chk = fbit & (ftSlot | fpsSlot);
   assign err = esf_q ? (rxBitVal != fpsExp) : (rxBitVal == lastFt_q);
   assign fsHit = rot_match({fsWin_q[4:0], rxBitVal}, FS_PAT);
   assign fsFound = fbit & fsSlot & mfLost_q & (fsCnt_q >= FS_FILL - 3'h1) & fsHit[3];
   assign fsFrame = {1'b0, fsHit[2:0], 1'b1};

   dsfr_oos_mon #(.WIN(WIDE_WIN)) u_oos (
      .ref_clk(ref_clk),
      .rst(rst),
      .chk(chk),
      .err(err),
      .wide(oosWide_q),
      .clr(lockNow),
      .lost(oosLost)
   );

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxBit_q <= '0;
         rxFrame_q <= '0;
         lastFt_q <= 1'b0;
         fsWin_q <= '0;
         fsCnt_q <= '0;
         termLost_q <= SYNC_LOST_RST;
         mfLost_q <= SYNC_LOST_RST;
         refOut_q <= 1'b0;
      end else begin
         rxBit_q <= rxBit_d;
         rxFrame_q <= rxFrame_d;
         refOut_q <= (rxBit_q < REF_HIGH_BITS);
         if (lockNow || (fbit && ftSlot)) begin
            lastFt_q <= rxBitVal;
         end
         if (lockNow) begin
            fsCnt_q <= '0;
         end else if (fbit && fsSlot) begin
            fsWin_q <= {fsWin_q[4:0], rxBitVal};
            if (fsCnt_q != FS_FILL) begin
               fsCnt_q <= fsCnt_q + 3'h1;
            end
         end
         if (dropSync) begin
            termLost_q <= 1'b1;
            mfLost_q <= 1'b1;
         end else if (lockNow) begin
            termLost_q <= 1'b0;
            mfLost_q <= ~esf_q;
         end else if (fsFound) begin
            mfLost_q <= 1'b0;
         end
      end
   end

   assign recoveredFrameRefOut = refOut_q;
   assign signallingFreeze = termLost_q;

   // -----------------------------------------------------------------
   // apb slave
   // -----------------------------------------------------------------
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wrEn = access & pwrite;
   assign selCtrl1 = (paddr == CTRL1_ADDR);
   assign selCtrl2 = (paddr == CTRL2_ADDR);
   assign selStat1 = (paddr == STAT1_ADDR);
   assign selPos = (paddr == POS_ADDR);
   assign mapped = selCtrl1 | selCtrl2 | selStat1 | selPos;
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign modeChg = wrEn & selCtrl1 & (pwdata[CTRL1_ESF_BIT] != esf_q);
   assign forceReframe = wrEn & selCtrl2 & pwdata[CTRL2_REFRAME_BIT];

   always_comb begin
      rdMux = 32'h0000_0000;
      if (selCtrl1) begin
         rdMux[CTRL1_ESF_BIT] = esf_q;
         rdMux[CTRL1_CRCMIM_BIT] = crcMimic_q;
      end else if (selCtrl2) begin
         rdMux[CTRL2_OOS_BIT] = oosWide_q;
      end else if (selStat1) begin
         rdMux[STAT_TERM_BIT] = termLost_q;
         rdMux[STAT_FREEZE_BIT] = termLost_q;
         rdMux[STAT_HUNT_BIT] = (state_q != FR_SYNC);
         rdMux[STAT_MF_BIT] = mfLost_q;
         rdMux[STAT_SPLIT_LSB +: 2] = split_q;
      end else if (selPos) begin
         rdMux[7:0] = rxBit_q;
         rdMux[POS_FRAME_LSB +: 5] = rxFrame_q;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         esf_q <= CTRL_RST;
         crcMimic_q <= CTRL_RST;
         oosWide_q <= CTRL_RST;
         prdata_q <= '0;
      end else begin
         if (setup) begin
            prdata_q <= rdMux;
         end
         if (wrEn && selCtrl1) begin
            esf_q <= pwdata[CTRL1_ESF_BIT];
            crcMimic_q <= pwdata[CTRL1_CRCMIM_BIT];
         end
         if (wrEn && selCtrl2) begin
            oosWide_q <= pwdata[CTRL2_OOS_BIT];
         end
      end
   end

   assign prdata = prdata_q;

endmodule // dsfr_framer

// [testbench/dsfr_framer_asserts.sv]
// checker for the framer bus and status ports
`timescale 1ns/1ps
module dsfr_framer_asserts import dsfr_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // framer
   input wire logic signallingFreeze
);
   wire logic acc = psel && penable;
   wire logic rdAcc = acc && !pwrite;
   wire logic mapped = paddr == CTRL1_ADDR || paddr == CTRL2_ADDR || paddr == STAT1_ADDR
      || paddr == POS_ADDR;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence rdSetup; psel && !penable && !pwrite; endsequence
   sequence rdCycle; rdSetup ##1 rdAcc; endsequence
   ready_acc_a: assert property (acc |-> pready) else $error("pready low in access");
   err_idle_a: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
   err_map_a: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
   unmapped_zero_a: assert property (rdAcc && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   rd_hold_a: assert property (rdCycle |=> $stable(prdata)) else $error("read data moved");
   stat_freeze_a:
      assert property (rdAcc && paddr == STAT1_ADDR |-> prdata[0] == $past(signallingFreeze))
      else $error("status and freeze differ");
   mf_term_a:
      assert property (rdAcc && paddr == STAT1_ADDR && prdata[0] |-> prdata[3])
      else $error("multiframe sync without frame sync");
   reframe_zero_a:
      assert property (rdAcc && paddr == CTRL2_ADDR |-> prdata[31:1] == 31'h0)
      else $error("reframe bit reads set");
   pos_range_a:
      assert property (rdAcc && paddr == POS_ADDR |-> prdata[7:0] <= FRAME_LAST_BIT)
      else $error("bit position out of frame");
   freeze_rst_a: assert property ($fell(rst) |-> signallingFreeze)
      else $error("freeze low after reset");
endmodule // dsfr_framer_asserts

bind dsfr_framer dsfr_framer_asserts i_dsfr_framer_asserts (.ref_clk(ref_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .signallingFreeze(signallingFreeze));

// [testbench/dsfr_line_model.sv]
// line receiver model: free-running line clock, framed ds1 data
`timescale 1ns/1ps
module dsfr_line_model import dsfr_pkg::*; (
   // bench control
   input wire logic ftBad,
   input wire logic fsBad,
   // line pins
   output logic extractedLineClockIn,
   output logic splitPhasePositiveInN,
   output logic splitPhaseNegativeInN,
   output logic compositeDataIn
);
   int seed = 82794;
   int bitIdx = 0;
   int frameIdx = 0;
   logic mark;
   logic pol = 1'b0;
   initial begin
      extractedLineClockIn = 1'b0;
      compositeDataIn = 1'b0;
      splitPhasePositiveInN = 1'b1;
      splitPhaseNegativeInN = 1'b1;
      #3.1;
      forever #12.5 extractedLineClockIn = ~extractedLineClockIn;
   end
   // data moves on the rising edge, steady at the falling edge
   always @(posedge extractedLineClockIn) begin
      // sparse marks keep mimics rare
      mark = &3'($random(seed));
      if (bitIdx == 0 && frameIdx[0] == 1'b0 && !ftBad) mark = !frameIdx[1];
      if (bitIdx == 0 && frameIdx[0] == 1'b1 && !fsBad) mark = FS_PAT[5 - frameIdx / 2];
      compositeDataIn <= mark;
      splitPhasePositiveInN <= !(mark && !pol);
      splitPhaseNegativeInN <= !(mark && pol);
      if (mark) pol = !pol;
      bitIdx = (bitIdx == BITS_PER_FRAME - 1) ? 0 : bitIdx + 1;
      if (bitIdx == 0) frameIdx = (frameIdx + 1) % 12;
   end
endmodule // dsfr_line_model

// [testbench/tb.sv]
// self-checking bench for the ds1 off-line framer
`timescale 1ns/1ps
module tb import dsfr_pkg::*; ;
   typedef struct {logic [31:0] val; logic [31:0] mask; logic err;} dsfr_exp_t;
   dsfr_exp_t expQ[$];
   dsfr_exp_t e;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic chkRd = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, lineClk, posN, negN, dataIn, frameRef, freeze;
   logic ftBad = 1'b0;
   logic fsBad = 1'b0;
   logic refChk = 1'b0;
   logic armed = 1'b0;
   logic refPrev = 1'b0;
   int errors = 0;
   int checks = 0;
   int bitCnt = 0;
   int seed = 82794;

   always #2 ref_clk = ~ref_clk;

   dsfr_framer i_dsfr_framer (.ref_clk(ref_clk), .rst(rst), .extractedLineClockIn(lineClk),
      .splitPhasePositiveInN(posN), .splitPhaseNegativeInN(negN), .compositeDataIn(dataIn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .recoveredFrameRefOut(frameRef),
      .signallingFreeze(freeze));
   dsfr_line_model i_dsfr_line_model (.ftBad(ftBad), .fsBad(fsBad),
      .extractedLineClockIn(lineClk), .splitPhasePositiveInN(posN),
      .splitPhaseNegativeInN(negN), .compositeDataIn(dataIn));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic c);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      chkRd <= c;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         errors++;
         finish_test();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      chkRd <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
      input logic err);
      expQ.push_back('{v, m, err});
      apb(1'b0, a, 32'h0, 1'b1);
   endtask

   task automatic waitStat(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, STAT1_ADDR, 32'h0, 1'b0);
         n++;
      end while (rd[b] !== v && n < 20000);
      if (rd[b] !== v) begin
         errors++;
         finish_test();
      end
   endtask

   // ---------------------------------------------------------------
   // monitors
   // ---------------------------------------------------------------
   always @(negedge lineClk) bitCnt++;
   always @(posedge ref_clk) begin
      if (psel && penable && pready && chkRd && expQ.size() > 0) begin
         e = expQ.pop_front();
         check("read data", prdata & e.mask, e.val);
         check("slave error", 32'(pslverr), 32'(e.err));
      end
      refPrev <= frameRef;
      if (frameRef && !refPrev) begin
         if (armed) check("ref period", 32'(bitCnt), 32'(BITS_PER_FRAME));
         armed <= refChk;
         bitCnt = 0;
      end
      if (!frameRef && refPrev && armed) check("ref high", 32'(bitCnt), 32'(REF_HIGH_BITS));
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rdChk(STAT1_ADDR, 32'h0F, 32'h0F, 1'b0);
      rdChk(CTRL2_ADDR, 32'h0, 32'hFFFFFFFF, 1'b0);
      rdChk(CTRL1_ADDR, 32'h0, 32'h3, 1'b0);
      apb(1'b1, 8'h10, $random(seed), 1'b0);
      rdChk(8'h10, 32'h0, 32'hFFFFFFFF, 1'b1);
      apb(1'b1, STAT1_ADDR, $random(seed), 1'b0);
      rdChk(STAT1_ADDR, 32'h0F, 32'h0F, 1'b0);
      apb(1'b1, CTRL2_ADDR, 32'h1, 1'b0);
      rdChk(CTRL2_ADDR, 32'h1, 32'h3, 1'b0);
      apb(1'b1, CTRL2_ADDR, 32'h0, 1'b0);
      $display("registers done");
      waitStat(STAT_TERM_BIT, 1'b0);
      refChk <= 1'b1;
      check("freeze", 32'(freeze), 32'h0);
      waitStat(STAT_MF_BIT, 1'b0);
      fsBad <= 1'b1;
      repeat (5000) @(posedge ref_clk);
      rdChk(STAT1_ADDR, 32'h0, 32'h5, 1'b0);
      fsBad <= 1'b0;
      $display("lock done");
      apb(1'b1, CTRL2_ADDR, 32'h2, 1'b0);
      rdChk(STAT1_ADDR, 32'h9, 32'h9, 1'b0);
      waitStat(STAT_TERM_BIT, 1'b0);
      $display("reframe done");
      ftBad <= 1'b1;
      waitStat(STAT_TERM_BIT, 1'b1);
      rdChk(STAT1_ADDR, 32'h0F, 32'h0F, 1'b0);
      $display("loss done");
      finish_test();
   end
endmodule // tb
